// *** src/ipb_bank.sv ***
// Notes on behaviour
// - each 3-bit field is the source's level in plain binary, 111 highest and 001 lowest active.
// - a field of 000 disables its source so it never requests service whatever its flag.
// - bits that hold no field ignore writes and read as zero.
// - after reset every field holds 100 and every field is readable and writable.
// - the external interrupt 1 register holds ext_int1_level in bits 2..0, bits 15..3 unused.
// - the external interrupt 2 register holds ext_int2_level in bits 6..4, the rest unused.
// - the special event register holds pwm_special_event_level in bits 6..4, the rest unused.
// - the uart error register holds uart_error_level in bits 6..4, the rest unused.
// - the pwm 1/2 register holds pwm_gen1_level in bits 10..8 and pwm_gen2_level in bits 14..12.
// - the pwm 3/4 register holds pwm_gen3_level in bits 2..0 and pwm_gen4_level in bits 6..4.
// - the comparator 2 register holds comparator2_level in bits 14..12, the rest unused.
// - the comparator 3/4 register holds comparator3_level in bits 2..0 and comparator4_level in bits 6..4.
// - after reset all sources sit at level 4.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module ipb_bank
    import ipb_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [IPB_NUM_FIELDS-1:0] src_flag,
    output logic [IPB_NUM_FIELDS-1:0] src_enabled,
    output logic [IPB_NUM_FIELDS-1:0] src_request,
    output logic [2:0] ext_int1_level,
    output logic [2:0] ext_int2_level,
    output logic [2:0] pwm_special_event_level,
    output logic [2:0] uart_error_level,
    output logic [2:0] pwm_gen1_level,
    output logic [2:0] pwm_gen2_level,
    output logic [2:0] pwm_gen3_level,
    output logic [2:0] pwm_gen4_level,
    output logic [2:0] comparator2_level,
    output logic [2:0] comparator3_level,
    output logic [2:0] comparator4_level
);

    ipb_state_t st;
    ipb_state_t next_st;
    logic [3:0] dec;
    logic hit;
    logic [2:0] slot;
    logic setup_rd;
    logic acc;
    logic wr_acc;

    // address to {hit, slot}; word aligned only
    function automatic logic [3:0] ipb_decode(input logic [ADDR_W-1:0] addr);
        logic [3:0] r;
        r = 4'h0;
        for (int s = 0; s < IPB_NUM_REGS; s++) begin
            if (addr == ADDR_W'({IPB_REG_IDX[s], 2'b00})) begin
                r = {1'b1, 3'(s)};
            end
        end
        return r;
    endfunction

    // read word of one slot, unused bits zero
    function automatic logic [IPB_REG_W-1:0] ipb_word(
        input logic [2:0] s,
        input logic [IPB_NUM_FIELDS-1:0][IPB_LVL_W-1:0] lv
    );
        logic [IPB_REG_W-1:0] w;
        w = 16'h0000;
        for (int f = 0; f < IPB_NUM_FIELDS; f++) begin
            if (IPB_FLD_SLOT[f] == s) begin
                w[IPB_FLD_LSB[f] +: IPB_LVL_W] = lv[f];
            end
        end
        return w;
    endfunction

    // mask of implemented bits in one slot
    function automatic logic [IPB_REG_W-1:0] ipb_mask(input logic [2:0] s);
        logic [IPB_REG_W-1:0] m;
        m = 16'h0000;
        for (int f = 0; f < IPB_NUM_FIELDS; f++) begin
            if (IPB_FLD_SLOT[f] == s) begin
                m[IPB_FLD_LSB[f] +: IPB_LVL_W] = 3'h7;
            end
        end
        return m;
    endfunction

    // bus phase decode
    assign dec = ipb_decode(paddr);
    assign hit = dec[3];
    assign slot = dec[2:0];
    assign setup_rd = psel & ~penable & ~pwrite;
    assign acc = psel & penable;
    assign wr_acc = acc & pwrite & hit;

    // zero wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata = st.rdata;

    // next state of the bank
    always_comb begin
        next_st = st;
        if (setup_rd) begin
            next_st.rdata = hit ? {16'h0000, ipb_word(slot, st.lvl)} : 32'h0000_0000;
        end
        if (wr_acc) begin
            for (int f = 0; f < IPB_NUM_FIELDS; f++) begin
                if (IPB_FLD_SLOT[f] == slot && pstrb[IPB_FLD_LSB[f][3]]) begin
                    next_st.lvl[f] = pwdata[IPB_FLD_LSB[f] +: IPB_LVL_W];
                end
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= IPB_STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign ext_int1_level = st.lvl[IPB_F_EXT_INT1];
    assign ext_int2_level = st.lvl[IPB_F_EXT_INT2];
    assign pwm_special_event_level = st.lvl[IPB_F_PWM_SPECIAL_EVENT];
    assign uart_error_level = st.lvl[IPB_F_UART_ERROR];
    assign pwm_gen1_level = st.lvl[IPB_F_PWM_GEN1];
    assign pwm_gen2_level = st.lvl[IPB_F_PWM_GEN2];
    assign pwm_gen3_level = st.lvl[IPB_F_PWM_GEN3];
    assign pwm_gen4_level = st.lvl[IPB_F_PWM_GEN4];
    assign comparator2_level = st.lvl[IPB_F_COMPARATOR2];
    assign comparator3_level = st.lvl[IPB_F_COMPARATOR3];
    assign comparator4_level = st.lvl[IPB_F_COMPARATOR4];

    ipb_level_gate #(
        .N(IPB_NUM_FIELDS)
    ) u_gate (
        .level(st.lvl),
        .flag(src_flag),
        .enabled(src_enabled),
        .request(src_request)
    );

    // first cycle after reset release, for checks only
    logic seen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // reset values and checks on reads and writes
    a_reset_all_four: assert property (!seen_q |-> st.lvl == {IPB_NUM_FIELDS{3'h4}})
        else $error("levels not four after reset");
    a_reset_ext1_out: assert property (!seen_q |-> ext_int1_level == 3'h4 && comparator4_level == 3'h4)
        else $error("outputs not level four after reset");
    a_write_lands: assert property (
        wr_acc && slot == 3'h0 && pstrb[0] |=> ext_int1_level == $past(pwdata[2:0]))
        else $error("write to ext int1 field lost");
    a_no_write_stable: assert property (!wr_acc |=> $stable(st.lvl))
        else $error("level changed without a write");
    a_disabled_quiet: assert property ((src_request & ~src_enabled) == 11'h000)
        else $error("disabled source requests");
    a_flag_passes: assert property (
        src_flag[IPB_F_UART_ERROR] && uart_error_level != 3'h0 |-> src_request[IPB_F_UART_ERROR])
        else $error("enabled flag not passed");
    a_unused_zero: assert property (
        acc && !pwrite && hit |-> (prdata & ~{16'h0000, ipb_mask(slot)}) == 32'h0000_0000)
        else $error("unused bits read nonzero");
    a_read_ext2: assert property (
        setup_rd && hit && slot == 3'h1 ##1 acc |-> prdata[6:4] == ext_int2_level)
        else $error("ext int2 read wrong");
    a_read_pwm12: assert property (
        setup_rd && hit && slot == 3'h4 ##1 acc |-> prdata[10:8] == pwm_gen1_level
        && prdata[14:12] == pwm_gen2_level)
        else $error("pwm 1/2 read wrong");
    a_read_cmp34: assert property (
        setup_rd && hit && slot == 3'h7 ##1 acc |-> prdata[2:0] == comparator3_level
        && prdata[6:4] == comparator4_level)
        else $error("comparator 3/4 read wrong");
    a_unmapped_err: assert property (acc && !hit |-> pslverr && pready)
        else $error("unmapped access not refused");

    // main scenarios
    c_write_disable: cover property (wr_acc ##1 src_enabled != 11'h7ff);
    c_read_back: cover property (wr_acc ##1 setup_rd ##1 acc);
    c_unmapped: cover property (acc && !hit);
    c_request: cover property (src_request[IPB_F_PWM_GEN3]);

endmodule

`default_nettype wire

// *** common/ipb_pkg.sv ***
package ipb_pkg;

    // field and register geometry
    localparam int IPB_NUM_FIELDS = 11;
    localparam int IPB_NUM_REGS = 8;
    localparam int IPB_LVL_W = 3;
    localparam int IPB_REG_W = 16;

    // level encodings: zero disables, reset places a source at level four
    localparam logic [2:0] IPB_LVL_OFF = 3'h0;
    localparam logic [2:0] IPB_LVL_RESET = 3'h4;

    // register indices; byte address is four times the index
    localparam logic [7:0] IPB_IDX_EXT_INT1_PRIORITY_REG = 8'h05;
    localparam logic [7:0] IPB_IDX_EXT_INT2_PRIORITY_REG = 8'h07;
    localparam logic [7:0] IPB_IDX_PWM_SPECIAL_EVENT_PRIORITY_REG = 8'h0e;
    localparam logic [7:0] IPB_IDX_UART_ERROR_PRIORITY_REG = 8'h10;
    localparam logic [7:0] IPB_IDX_PWM_GEN12_PRIORITY_REG = 8'h17;
    localparam logic [7:0] IPB_IDX_PWM_GEN34_PRIORITY_REG = 8'h18;
    localparam logic [7:0] IPB_IDX_COMPARATOR2_PRIORITY_REG = 8'h19;
    localparam logic [7:0] IPB_IDX_COMPARATOR34_PRIORITY_REG = 8'h1a;

    // slot number to register index
    localparam logic [7:0] IPB_REG_IDX [IPB_NUM_REGS] = '{
        IPB_IDX_EXT_INT1_PRIORITY_REG, IPB_IDX_EXT_INT2_PRIORITY_REG,
        IPB_IDX_PWM_SPECIAL_EVENT_PRIORITY_REG, IPB_IDX_UART_ERROR_PRIORITY_REG,
        IPB_IDX_PWM_GEN12_PRIORITY_REG, IPB_IDX_PWM_GEN34_PRIORITY_REG,
        IPB_IDX_COMPARATOR2_PRIORITY_REG, IPB_IDX_COMPARATOR34_PRIORITY_REG
    };

    // field numbers
    localparam int IPB_F_EXT_INT1 = 0;
    localparam int IPB_F_EXT_INT2 = 1;
    localparam int IPB_F_PWM_SPECIAL_EVENT = 2;
    localparam int IPB_F_UART_ERROR = 3;
    localparam int IPB_F_PWM_GEN1 = 4;
    localparam int IPB_F_PWM_GEN2 = 5;
    localparam int IPB_F_PWM_GEN3 = 6;
    localparam int IPB_F_PWM_GEN4 = 7;
    localparam int IPB_F_COMPARATOR2 = 8;
    localparam int IPB_F_COMPARATOR3 = 9;
    localparam int IPB_F_COMPARATOR4 = 10;

    // slot holding each field
    localparam logic [2:0] IPB_FLD_SLOT [IPB_NUM_FIELDS] = '{
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h7, 3'h7
    };

    // lowest bit position of each field
    localparam logic [3:0] IPB_FLD_LSB [IPB_NUM_FIELDS] = '{
        4'h0, 4'h4, 4'h4, 4'h4, 4'h8, 4'hc, 4'h0, 4'h4, 4'hc, 4'h0, 4'h4
    };

    // whole state of the bank
    typedef struct packed {
        logic [IPB_NUM_FIELDS-1:0][IPB_LVL_W-1:0] lvl;
        logic [31:0] rdata;
    } ipb_state_t;

    localparam ipb_state_t IPB_STATE_RESET = '{
        lvl: {IPB_NUM_FIELDS{IPB_LVL_RESET}},
        rdata: 32'h0000_0000
    };

endpackage

// *** src/ipb_level_gate.sv ***
`timescale 1ns/100ps
`default_nettype none

module ipb_level_gate
    import ipb_pkg::*;
#(
    parameter int N = IPB_NUM_FIELDS
) (
    input wire logic [N-1:0][IPB_LVL_W-1:0] level,
    input wire logic [N-1:0] flag,
    output logic [N-1:0] enabled,
    output logic [N-1:0] request
);

    // per source: a zero level blocks the flag entirely
    for (genvar g = 0; g < N; g++) begin : g_src
        assign enabled[g] = (level[g] != IPB_LVL_OFF);
        assign request[g] = flag[g] & enabled[g];
    end

endmodule

`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import ipb_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [33:0] note_e;
    logic [3:0] pstrb;
    logic [10:0] src_flag, src_enabled, src_request;
    logic [10:0][2:0] lv_out, exp_lvl;
    logic [33:0] note_q [$];
    logic [2:0] rs;
    int n_errors, checked, seed;

    ipb_bank u_ipb_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_flag(src_flag), .src_enabled(src_enabled), .src_request(src_request),
        .ext_int1_level(lv_out[0]), .ext_int2_level(lv_out[1]), .pwm_special_event_level(lv_out[2]),
        .uart_error_level(lv_out[3]), .pwm_gen1_level(lv_out[4]), .pwm_gen2_level(lv_out[5]),
        .pwm_gen3_level(lv_out[6]), .pwm_gen4_level(lv_out[7]), .comparator2_level(lv_out[8]),
        .comparator3_level(lv_out[9]), .comparator4_level(lv_out[10]));

    // free-running clock, 10 ns period
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("counts: checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // expected register image built from the field table
    function automatic logic [31:0] reg_val(input logic [2:0] s);
        logic [31:0] v;
        v = 32'h0;
        for (int f = 0; f < IPB_NUM_FIELDS; f++)
            if (IPB_FLD_SLOT[f] == s) v[IPB_FLD_LSB[f] +: 3] = exp_lvl[f];
        return v;
    endfunction

    // one apb transfer, expectation queued before the request
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                       input logic [31:0] ed, input logic ee);
        note_q.push_back({wr, ee, ed});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i <= 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
            if (i == 20) begin
                n_errors++;
                $display("Error at %0t: no pready", $time);
                finish_test();
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [11:0] adr(input logic [2:0] s);
        return {2'b00, IPB_REG_IDX[s], 2'b00};
    endfunction

    task automatic wr_reg(input logic [2:0] s, input logic [31:0] d, input logic [3:0] st);
        for (int f = 0; f < IPB_NUM_FIELDS; f++)
            if (IPB_FLD_SLOT[f] == s && (IPB_FLD_LSB[f] < 8 ? st[0] : st[1]))
                exp_lvl[f] = d[IPB_FLD_LSB[f] +: 3];
        apb(1'b1, adr(s), d, st, 32'h0, 1'b0);
    endtask

    task automatic rd_all();
        for (int s = 0; s < IPB_NUM_REGS; s++)
            apb(1'b0, adr(3'(s)), 32'h0, 4'h0, reg_val(3'(s)), 1'b0);
    endtask

    task automatic chk_lvl();
        @(negedge pclk);
        for (int f = 0; f < IPB_NUM_FIELDS; f++) begin
            cmp_val(lv_out[f], exp_lvl[f], "level");
            cmp_val(src_request[f], src_flag[f] & (exp_lvl[f] != 3'h0), "request");
            cmp_val(src_enabled[f], exp_lvl[f] != 3'h0, "enabled");
        end
        @(posedge pclk);
    endtask

    // bus monitor: takes the oldest note at each completed transfer
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            note_e = note_q.pop_front();
            cmp_val(pslverr, 32'(note_e[32]), "slverr");
            if (!note_e[33]) cmp_val(prdata, note_e[31:0], "rdata");
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, src_flag} = '0;
        seed = 60765;
        n_errors = 0;
        checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        exp_lvl = {IPB_NUM_FIELDS{IPB_LVL_RESET}};
        chk_lvl();
        rd_all();
        $display("test reset_values done");
        // every code in every field, flags all raised
        src_flag <= 11'h7ff;
        for (int c = 0; c < 8; c++) begin
            for (int s = 0; s < IPB_NUM_REGS; s++) wr_reg(3'(s), {8{1'b1, 3'(c)}}, 4'hf);
            rd_all();
            chk_lvl();
        end
        $display("test level_codes done");
        // random data, strobes and flags
        repeat (60) begin
            rs = 3'($random(seed));
            src_flag <= 11'($random(seed));
            wr_reg(rs, $random(seed), 4'($random(seed)));
            apb(1'b0, adr(rs), 32'h0, 4'h0, reg_val(rs), 1'b0);
            chk_lvl();
        end
        $display("test random_writes done");
        // unmapped and unaligned places are refused
        apb(1'b1, 12'h000, 32'hffff_ffff, 4'hf, 32'h0, 1'b1);
        apb(1'b1, 12'h015, 32'h0000_0000, 4'hf, 32'h0, 1'b1);
        apb(1'b0, 12'h018, 32'h0, 4'h0, 32'h0, 1'b1);
        rd_all();
        $display("test unmapped done");
        // reset in mid-run restores level four
        for (int s = 0; s < IPB_NUM_REGS; s++) wr_reg(3'(s), 32'h0000_7777, 4'hf);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        exp_lvl = {IPB_NUM_FIELDS{IPB_LVL_RESET}};
        chk_lvl();
        rd_all();
        $display("test mid_reset done");
        finish_test();
    end
endmodule

`default_nettype wire
